// ---- include/sbcsr_pkg.sv ----
// Shared constants and carrier types for the status readout block
package sbcsr_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame layout
   localparam int FRAME_BITS = 16;
   localparam logic [4:0] CMD_END_CNT = 5'h08;
   localparam logic [4:0] FRAME_END_CNT = 5'h10;

   // Group prefixes in command bits 15-14
   localparam logic [1:0] PREFIX_REAL_TIME = 2'h0;
   localparam logic [1:0] PREFIX_FLAG = 2'h3;

   // Five-bit group addresses in command bits 13-9
   localparam logic [4:0] ADDR_IO = 5'h11;
   localparam logic [4:0] ADDR_SAFE = 5'h12;
   localparam logic [4:0] ADDR_LIN1 = 5'h13;
   localparam logic [4:0] ADDR_LIN2 = 5'h14;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions in the answered byte
   localparam int IO0_POS = 0;
   localparam int IO1_POS = 2;
   localparam int IO2_POS = 4;
   localparam int IO3_POS = 6;
   localparam int LIVE_STATE_POS = 7;
   localparam int LIVE_WAKE_POS = 6;

   // Implemented bits of each latched flag byte
   localparam logic [7:0] SAFE_A_MASK = 8'hfe;
   localparam logic [7:0] SAFE_B_MASK = 8'h1f;
   localparam logic [7:0] LIN1_MASK = 8'h77;
   localparam logic [7:0] LIN2_MASK = 8'h7f;

   // Index of each latched byte
   localparam int FLAG_SAFE_A = 0;
   localparam int FLAG_SAFE_B = 1;
   localparam int FLAG_LIN1 = 2;
   localparam int FLAG_LIN2 = 3;
   localparam int FLAG_BYTES = 4;

   localparam logic [7:0] FLAG_RESET = 8'h00;

   // Identification defaults; values are arbitrary
   localparam logic [4:0] SILICON_ID_DEFAULT = 5'h0a;
   localparam logic [1:0] PART_VARIANT_DEFAULT = 2'h1;

   ////////////////////////////////////////////////////////////////////////////////
   // Byte source picked by one command
   typedef enum logic [8:0] {
      SRC_NONE   = 9'h001,
      SRC_IO     = 9'h002,
      SRC_SAFE_A = 9'h004,
      SRC_SAFE_B = 9'h008,
      SRC_IDENT  = 9'h010,
      SRC_LIN1_F = 9'h020,
      SRC_LIN1_L = 9'h040,
      SRC_LIN2_F = 9'h080,
      SRC_LIN2_L = 9'h100
   } sbcsr_src_e;

   // Fault conditions, already in answer bit layout
   typedef struct packed {
      logic [7:0] safe_a;
      logic [7:0] safe_b;
      logic [7:0] lin1;
      logic [7:0] lin2;
   } sbcsr_cond_s;

   // Live levels
   typedef struct packed {
      logic [3:0] io_level;
      logic lin1_state;
      logic lin1_wake_receiver;
      logic lin2_state;
      logic lin2_wake_receiver;
      logic vdd_is_5v0;
   } sbcsr_live_s;

   // Serial pins from the host
   typedef struct packed {
      logic sclk;
      logic cs_b;
      logic mosi;
   } sbcsr_spi_s;

endpackage

// ---- hw/sbcsr_sync.sv ----
// Two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module sbcsr_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // Stage1 is read only by sync_out
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// ---- hw/sbcsr_status_readout.sv ----
// Serial status and flag readout: live levels, latched faults and identification
`timescale 1ns/1ps
module sbcsr_status_readout #(
   parameter logic [4:0] SILICON_ID = sbcsr_pkg::SILICON_ID_DEFAULT,
   parameter logic [1:0] PART_VARIANT = sbcsr_pkg::PART_VARIANT_DEFAULT
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire sbcsr_pkg::sbcsr_spi_s spi_in,
   output logic miso,
   output logic miso_oe,
   input wire sbcsr_pkg::sbcsr_cond_s fault_cond,
   input wire sbcsr_pkg::sbcsr_live_s live_in
);

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers

   sbcsr_pkg::sbcsr_spi_s spi_s;
   sbcsr_pkg::sbcsr_cond_s cond_s;
   sbcsr_pkg::sbcsr_live_s live_s;

   sbcsr_sync #(
      .WIDTH(3),
      .RESET_VALUE(3'h2)
   ) u_spi_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .async_in(spi_in),
      .sync_out(spi_s)
   );

   sbcsr_sync #(
      .WIDTH(32)
   ) u_cond_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .async_in(fault_cond),
      .sync_out(cond_s)
   );

   sbcsr_sync #(
      .WIDTH(9)
   ) u_live_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .async_in(live_in),
      .sync_out(live_s)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Command decoding

   function automatic sbcsr_pkg::sbcsr_src_e sbcsr_decode(input logic [7:0] cmd,
                                                          input logic sel);
      logic [1:0] prefix;
      logic [4:0] addr;
      sbcsr_pkg::sbcsr_src_e src;
      prefix = cmd[7:6];
      addr = cmd[5:1];
      src = sbcsr_pkg::SRC_NONE;
      if (cmd[0]) begin
         if (prefix == sbcsr_pkg::PREFIX_REAL_TIME && sel) begin
            case (addr)
               sbcsr_pkg::ADDR_IO: src = sbcsr_pkg::SRC_IO;
               sbcsr_pkg::ADDR_SAFE: src = sbcsr_pkg::SRC_IDENT;
               sbcsr_pkg::ADDR_LIN1: src = sbcsr_pkg::SRC_LIN1_L;
               sbcsr_pkg::ADDR_LIN2: src = sbcsr_pkg::SRC_LIN2_L;
               default: src = sbcsr_pkg::SRC_NONE;
            endcase
         end else if (prefix == sbcsr_pkg::PREFIX_FLAG) begin
            case ({addr, sel})
               {sbcsr_pkg::ADDR_SAFE, 1'b0}: src = sbcsr_pkg::SRC_SAFE_A;
               {sbcsr_pkg::ADDR_SAFE, 1'b1}: src = sbcsr_pkg::SRC_SAFE_B;
               {sbcsr_pkg::ADDR_LIN1, 1'b0}: src = sbcsr_pkg::SRC_LIN1_F;
               {sbcsr_pkg::ADDR_LIN2, 1'b0}: src = sbcsr_pkg::SRC_LIN2_F;
               default: src = sbcsr_pkg::SRC_NONE;
            endcase
         end
      end
      return src;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Frame tracking and answer shifter

   logic sclk_d;
   logic cs_b_d;
   logic [4:0] bit_cnt;
   logic [7:0] cmd;
   logic [7:0] answer;
   logic [7:0] reported;
   sbcsr_pkg::sbcsr_src_e src;
   logic [4:0] next_bit_cnt;
   logic [7:0] next_cmd;
   logic [7:0] next_answer;
   logic [7:0] next_reported;
   sbcsr_pkg::sbcsr_src_e next_src;
   logic next_miso;
   logic sclk_rise;
   logic frame_end;
   logic [7:0] flags [sbcsr_pkg::FLAG_BYTES];
   logic [7:0] answer_byte;
   sbcsr_pkg::sbcsr_src_e src_now;

   assign sclk_rise = spi_s.sclk && !sclk_d && !spi_s.cs_b;
   // Frames shorter than 16 clocks are ignored (longer ones hold the count at 16 and still end), so a short glitched frame never clears flags
   assign frame_end = spi_s.cs_b && !cs_b_d && bit_cnt == sbcsr_pkg::FRAME_END_CNT;
   assign src_now = sbcsr_decode(cmd, spi_s.mosi);
   // Enable drops one cycle after select, once the answer line has returned to zero
   assign miso_oe = !spi_s.cs_b || !cs_b_d;

   always_comb begin
      answer_byte = 8'h00;
      case (src_now)
         sbcsr_pkg::SRC_IO: begin
            answer_byte[sbcsr_pkg::IO0_POS] = live_s.io_level[0];
            answer_byte[sbcsr_pkg::IO1_POS] = live_s.io_level[1];
            answer_byte[sbcsr_pkg::IO2_POS] = live_s.io_level[2];
            answer_byte[sbcsr_pkg::IO3_POS] = live_s.io_level[3];
         end
         sbcsr_pkg::SRC_IDENT: answer_byte = {live_s.vdd_is_5v0, PART_VARIANT, SILICON_ID};
         sbcsr_pkg::SRC_SAFE_A: answer_byte = flags[sbcsr_pkg::FLAG_SAFE_A];
         sbcsr_pkg::SRC_SAFE_B: answer_byte = flags[sbcsr_pkg::FLAG_SAFE_B];
         sbcsr_pkg::SRC_LIN1_F: answer_byte = flags[sbcsr_pkg::FLAG_LIN1];
         sbcsr_pkg::SRC_LIN2_F: answer_byte = flags[sbcsr_pkg::FLAG_LIN2];
         sbcsr_pkg::SRC_LIN1_L: begin
            answer_byte[sbcsr_pkg::LIVE_STATE_POS] = live_s.lin1_state;
            answer_byte[sbcsr_pkg::LIVE_WAKE_POS] = live_s.lin1_wake_receiver;
         end
         sbcsr_pkg::SRC_LIN2_L: begin
            answer_byte[sbcsr_pkg::LIVE_STATE_POS] = live_s.lin2_state;
            answer_byte[sbcsr_pkg::LIVE_WAKE_POS] = live_s.lin2_wake_receiver;
         end
         default: answer_byte = 8'h00;
      endcase
   end

   // Answer bit n leaves on the rising edge where command bit n is taken,
   // so the selector in bit 7 is known in time; the host samples on falling edges
   always_comb begin
      next_bit_cnt = bit_cnt;
      next_cmd = cmd;
      next_answer = answer;
      next_reported = reported;
      next_src = src;
      next_miso = miso;
      if (spi_s.cs_b) begin
         next_bit_cnt = 5'h00;
         next_miso = 1'b0;
         if (frame_end == 1'b0 && cs_b_d) begin
            next_src = sbcsr_pkg::SRC_NONE;
         end
      end else if (spi_s.cs_b == 1'b0 && cs_b_d) begin
         next_src = sbcsr_pkg::SRC_NONE;
         next_bit_cnt = 5'h00;
         next_miso = 1'b0;
      end else if (sclk_rise && bit_cnt != sbcsr_pkg::FRAME_END_CNT) begin
         next_bit_cnt = bit_cnt + 5'h01;
         if (bit_cnt < sbcsr_pkg::CMD_END_CNT) begin
            next_cmd = {cmd[6:0], spi_s.mosi};
            next_miso = 1'b0;
         end else if (bit_cnt == sbcsr_pkg::CMD_END_CNT) begin
            next_src = src_now;
            next_reported = answer_byte;
            next_answer = {answer_byte[6:0], 1'b0};
            next_miso = answer_byte[7];
         end else begin
            next_answer = {answer[6:0], 1'b0};
            next_miso = answer[7];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sclk_d <= 1'b0;
         cs_b_d <= 1'b1;
         bit_cnt <= 5'h00;
         cmd <= 8'h00;
         answer <= 8'h00;
         reported <= 8'h00;
         src <= sbcsr_pkg::SRC_NONE;
         miso <= 1'b0;
      end else begin
         sclk_d <= spi_s.sclk;
         cs_b_d <= spi_s.cs_b;
         bit_cnt <= next_bit_cnt;
         cmd <= next_cmd;
         answer <= next_answer;
         reported <= next_reported;
         src <= next_src;
         miso <= next_miso;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Latched fault flags

   localparam logic [7:0] FLAG_MASK [sbcsr_pkg::FLAG_BYTES] = '{
      sbcsr_pkg::SAFE_A_MASK, sbcsr_pkg::SAFE_B_MASK,
      sbcsr_pkg::LIN1_MASK, sbcsr_pkg::LIN2_MASK
   };

   logic [7:0] cond_byte [sbcsr_pkg::FLAG_BYTES];
   logic [sbcsr_pkg::FLAG_BYTES-1:0] read_hit;
   logic [7:0] next_flags [sbcsr_pkg::FLAG_BYTES];

   assign cond_byte[sbcsr_pkg::FLAG_SAFE_A] = cond_s.safe_a;
   assign cond_byte[sbcsr_pkg::FLAG_SAFE_B] = cond_s.safe_b;
   assign cond_byte[sbcsr_pkg::FLAG_LIN1] = cond_s.lin1;
   assign cond_byte[sbcsr_pkg::FLAG_LIN2] = cond_s.lin2;
   assign read_hit = {src == sbcsr_pkg::SRC_LIN2_F, src == sbcsr_pkg::SRC_LIN1_F,
                      src == sbcsr_pkg::SRC_SAFE_B, src == sbcsr_pkg::SRC_SAFE_A};

   genvar gi;
   generate
      for (gi = 0; gi < sbcsr_pkg::FLAG_BYTES; gi++) begin : g_flag
         logic [7:0] clear_bits;
         // Only bits the host actually saw are cleared; a new event wins over the clear
         always_comb begin
            clear_bits = 8'h00;
            if (frame_end && read_hit[gi]) begin
               clear_bits = reported & ~cond_byte[gi];
            end
            next_flags[gi] = ((flags[gi] & ~clear_bits) | cond_byte[gi]) & FLAG_MASK[gi];
         end
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               flags[gi] <= sbcsr_pkg::FLAG_RESET;
            end else begin
               flags[gi] <= next_flags[gi];
            end
         end
      end
   endgenerate

endmodule

// ---- sim/sbcsr_status_readout_assertions.sv ----
// Port checks for the serial status readout
`timescale 1ns/1ps
module sbcsr_status_readout_assertions #(
   parameter logic [4:0] SILICON_ID = sbcsr_pkg::SILICON_ID_DEFAULT,
   parameter logic [1:0] PART_VARIANT = sbcsr_pkg::PART_VARIANT_DEFAULT
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire sbcsr_pkg::sbcsr_spi_s spi_in,
   input wire logic miso,
   input wire logic miso_oe,
   input wire sbcsr_pkg::sbcsr_cond_s fault_cond,
   input wire sbcsr_pkg::sbcsr_live_s live_in
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   // Frame mirror with the design's synchroniser depth on clock and data; select and live levels are taken raw
   logic [2:0] sck;
   logic [2:0] sdi;
   logic [4:0] cnt;
   logic [7:0] cmd;
   logic [7:0] lb;
   logic [7:0] bv;
   logic [1:0] kind;
   logic [1:0] knd;
   logic chk;
   logic ebit;
   logic rise;
   assign rise = sck[1] && !sck[2] && !spi_in.cs_b;
   always_comb begin
      bv = 8'h00;
      kind = 2'h0;
      if (!cmd[0]) begin
         kind = 2'h3;
      end else if (cmd == 8'h23 && sdi[1]) begin
         bv = {1'b0, live_in.io_level[3], 1'b0, live_in.io_level[2],
               1'b0, live_in.io_level[1], 1'b0, live_in.io_level[0]};
         kind = 2'h1;
      end else if (cmd == 8'h25 && sdi[1]) begin
         bv = {live_in.vdd_is_5v0, PART_VARIANT, SILICON_ID};
         kind = 2'h2;
      end else if ((cmd == 8'h27 || cmd == 8'h29) && sdi[1]) begin
         bv[7] = (cmd == 8'h29) ? live_in.lin2_state : live_in.lin1_state;
         bv[6] = (cmd == 8'h29) ? live_in.lin2_wake_receiver : live_in.lin1_wake_receiver;
         kind = 2'h2;
      end
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sck <= 3'h0;
         sdi <= 3'h0;
         cnt <= 5'h00;
         cmd <= 8'h00;
         lb <= 8'h00;
         knd <= 2'h0;
         chk <= 1'b0;
         ebit <= 1'b0;
      end else begin
         sck <= {sck[1:0], spi_in.sclk};
         sdi <= {sdi[1:0], spi_in.mosi};
         chk <= rise && cnt[4:3] == 2'h1;
         if (spi_in.cs_b) begin
            cnt <= 5'h00;
         end else if (rise) begin
            cnt <= cnt + 5'h01;
         end
         if (rise && cnt < 5'h08) begin
            cmd <= {cmd[6:0], sdi[1]};
         end
         if (rise && cnt == 5'h08) begin
            lb <= bv;
            knd <= kind;
         end
         if (rise && cnt[4:3] == 2'h1) begin
            ebit <= (cnt == 5'h08) ? bv[7] : lb[3'h7 - cnt[2:0]];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_bit_due; ##[1:6] miso == ebit; endsequence
   sequence s_clock_low; (!spi_in.cs_b && !spi_in.sclk)[*6]; endsequence
   property p_oe_on; $fell(spi_in.cs_b) |-> ##[1:5] miso_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("enable late");
   property p_oe_off; $rose(spi_in.cs_b) |-> ##[1:5] !miso_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("enable stuck");
   property p_oe_idle; spi_in.cs_b[*5] |-> !miso_oe; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("enable idle");
   property p_quiet; !miso_oe |-> !miso; endproperty
   a_quiet: assert property (p_quiet) else $error("data idle");
   property p_head; !spi_in.cs_b && cnt < 5'h08 |-> !miso; endproperty
   a_head: assert property (p_head) else $error("head not zero");
   property p_hold; s_clock_low |-> $stable(miso); endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_io; chk && knd == 2'h1 |-> s_bit_due; endproperty
   a_io: assert property (p_io) else $error("pin level bit");
   property p_live; chk && knd == 2'h2 |-> s_bit_due; endproperty
   a_live: assert property (p_live) else $error("live bit");
   property p_refused; chk && knd == 2'h3 |-> s_bit_due; endproperty
   a_refused: assert property (p_refused) else $error("refused bit");
endmodule
bind sbcsr_status_readout sbcsr_status_readout_assertions #(.SILICON_ID(SILICON_ID),
   .PART_VARIANT(PART_VARIANT)) chk (.core_clk(core_clk), .rst_b(rst_b), .spi_in(spi_in),
   .miso(miso), .miso_oe(miso_oe), .fault_cond(fault_cond), .live_in(live_in));

// ---- sim/sbcsr_host_model.sv ----
// Host model: serial frames out, answer line sampled on clock falls
`timescale 1ns/1ps
module sbcsr_host_model (
   input wire logic core_clk,
   input wire logic miso,
   input wire logic miso_oe,
   output sbcsr_pkg::sbcsr_spi_s spi_out
);
   logic filler;
   logic line;
   // A released line toggles so a stale bit never reads as valid
   assign line = miso_oe ? miso : filler;
   initial begin
      spi_out = 3'b010;
      filler = 1'b0;
   end
   always @(posedge core_clk) begin
      filler <= ~filler;
   end
   task automatic frame(input logic [15:0] word, output logic [15:0] resp);
      @(negedge core_clk);
      spi_out.cs_b = 1'b0;
      repeat (4) @(negedge core_clk);
      for (int i = 15; i >= 0; i--) begin
         spi_out.mosi = word[i];
         repeat (8) @(negedge core_clk);
         spi_out.sclk = 1'b1;
         repeat (8) @(negedge core_clk);
         resp[i] = line;
         spi_out.sclk = 1'b0;
      end
      repeat (8) @(negedge core_clk);
      spi_out.cs_b = 1'b1;
      spi_out.mosi = ~spi_out.mosi;
      repeat (20) @(negedge core_clk);
   endtask
endmodule

// ---- sim/sbc_spi_status_readout_test.sv ----
// Self-checking bench for the serial status readout
`timescale 1ns/1ps
module sbc_spi_status_readout_test;
   logic core_clk;
   logic rst_b;
   sbcsr_pkg::sbcsr_spi_s spi_in;
   logic miso;
   logic miso_oe;
   sbcsr_pkg::sbcsr_cond_s fault_cond;
   sbcsr_pkg::sbcsr_live_s live_in;
   int num_errors;
   int tests_run;
   sbcsr_status_readout DUT (.core_clk(core_clk), .rst_b(rst_b), .spi_in(spi_in),
      .miso(miso), .miso_oe(miso_oe), .fault_cond(fault_cond), .live_in(live_in));
   sbcsr_host_model host (.core_clk(core_clk), .miso(miso), .miso_oe(miso_oe),
      .spi_out(spi_in));
   always #4 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      if (num_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] expected);
      tests_run++;
      if (seen !== expected) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
      end
   endtask
   task automatic xfer(input logic [15:0] word, input logic [7:0] expected);
      logic [15:0] resp;
      host.frame(word, resp);
      check(resp, {8'h00, expected});
   endtask
   task automatic set_in(input logic [31:0] c, input logic [8:0] l);
      @(negedge core_clk);
      fault_cond = c;
      live_in = l;
      repeat (4) @(negedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_live;
      set_in(32'h0000_0000, 9'h1ff);
      xfer(16'h2380, 8'h55);
      xfer(16'h2380, 8'h55);
      set_in(32'h0000_0000, 9'h140);
      xfer(16'h2380, 8'h44);
      set_in(32'h0000_0000, 9'h0bf);
      xfer(16'h2380, 8'h11);
      xfer(16'h2580, {1'b1, sbcsr_pkg::PART_VARIANT_DEFAULT,
         sbcsr_pkg::SILICON_ID_DEFAULT});
      set_in(32'h0000_0000, 9'h012);
      xfer(16'h2580, {1'b0, sbcsr_pkg::PART_VARIANT_DEFAULT,
         sbcsr_pkg::SILICON_ID_DEFAULT});
      xfer(16'h2780, 8'h80);
      xfer(16'h2980, 8'h40);
      set_in(32'h0000_0000, 9'h1ed);
      xfer(16'h2780, 8'h40);
      xfer(16'h2980, 8'h80);
   endtask
   // Pulse, held and cleared conditions per flag byte
   task automatic t_flags;
      logic [15:0] cmds [4];
      logic [7:0] masks [4];
      logic [31:0] c;
      cmds = '{16'he500, 16'he580, 16'he700, 16'he900};
      masks = '{8'hfe, 8'h1f, 8'h77, 8'h7f};
      for (int k = 0; k < 4; k++) begin
         c = 32'hff00_0000 >> (8 * k);
         set_in(c, 9'h000);
         set_in(32'h0000_0000, 9'h000);
         xfer(cmds[k], masks[k]);
         xfer(cmds[k], 8'h00);
         set_in(c, 9'h000);
         xfer(cmds[k], masks[k]);
         set_in(32'h0000_0000, 9'h000);
         xfer(cmds[k], masks[k]);
         xfer(cmds[k], 8'h00);
      end
   endtask
   task automatic t_refused;
      set_in(32'hffff_ffff, 9'h1ff);
      xfer(16'h2280, 8'h00);
      xfer(16'he780, 8'h00);
      set_in(32'h0000_0000, 9'h000);
   endtask
   // Reset in mid-run drops the latched flags; only the SAFE_A and LIN2 bytes are read back
   task automatic t_reset;
      set_in(32'hffff_ffff, 9'h000);
      set_in(32'h0000_0000, 9'h000);
      rst_b = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge core_clk);
      xfer(16'he500, 8'h00);
      xfer(16'he900, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #400_000;
      num_errors++;
      end_sim;
   end
   initial begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      fault_cond = '0;
      live_in = '0;
      num_errors = 0;
      tests_run = 0;
      repeat (6) @(negedge core_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge core_clk);
      t_live;
      t_flags;
      t_refused;
      t_reset;
      end_sim;
   end
endmodule
